// [rtl/aogc_defs.svh]
// register offsets, field positions, reset values and mode codes
`ifndef AOGC_DEFS_SVH
`define AOGC_DEFS_SVH

`define AOGC_ADDR_W         12
`define AOGC_OFS_OFFSET     12'h000
`define AOGC_OFS_GAIN       12'h004
`define AOGC_OFS_MODE       12'h008
`define AOGC_OFS_CUR_CTL    12'h00C
`define AOGC_OFS_TMP_CTL    12'h010
`define AOGC_OFS_RESULT     12'h014
`define AOGC_OFS_STATUS     12'h018

`define AOGC_RST_OFFSET     16'h0000
`define AOGC_RST_GAIN       16'h5555
`define AOGC_GAIN_ONE_SHIFT 14

`define AOGC_MODE_IDLE      3'h0
`define AOGC_MODE_CONT      3'h1
`define AOGC_MODE_SINGLE    3'h2
`define AOGC_MODE_SYS_ZERO  3'h5
`define AOGC_MODE_SYS_FULL  3'h6

`define AOGC_MODE_LO        0
`define AOGC_MODE_HI        2
`define AOGC_PWR_LO         3
`define AOGC_PWR_HI         4
`define AOGC_REF_HALF_BIT   5
`define AOGC_UNIPOLAR_BIT   6

`define AOGC_PWR_NORMAL     2'h0
`define AOGC_PWR_LOW        2'h1
`define AOGC_PWR_LOW_PLUS   2'h2

`define AOGC_SRC_N_BIT      13
`define AOGC_SRC_P_BIT      14
`define AOGC_TEST_LO        6
`define AOGC_TEST_HI        7
`define AOGC_PGA_LO         0
`define AOGC_PGA_HI         3
`define AOGC_TEST_REF_DIV   2'h2
`define AOGC_PGA_128        4'h7

`define AOGC_STAT_RDY_BIT   0
`define AOGC_STAT_BUSY_BIT  1

`endif

// [rtl/aogc_pkg.sv]
// types shared by the offset and gain correction block
package aogc_pkg;

  typedef enum logic [4:0] {
    AOGC_ST_IDLE = 5'b00001,
    AOGC_ST_CONV = 5'b00010,
    AOGC_ST_CALZ = 5'b00100,
    AOGC_ST_CALF = 5'b01000,
    AOGC_ST_DIV  = 5'b10000
  } aogc_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } aogc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } aogc_apb_rsp_t;

  typedef struct packed {
    logic [1:0] cur_src;
    logic [1:0] cur_test;
    logic       test_div_gain;
    logic [3:0] pga;
    logic [1:0] tmp_src;
    logic [1:0] tmp_test;
    logic       conv_run;
  } aogc_analog_t;

  typedef struct packed {
    aogc_state_t  st;
    logic [15:0]  off;
    logic [15:0]  gain;
    logic [2:0]   mode;
    logic [1:0]   pmode;
    logic         ref_half;
    logic         unipolar;
    logic [15:0]  cur_ctl;
    logic [15:0]  tmp_ctl;
    logic [15:0]  result;
    logic         rdy;
    logic         rvalid;
    logic [32:0]  acc;
    logic         nsamp;
    logic [32:0]  div_d;
    logic [15:0]  quo;
    logic [3:0]   bit_i;
    logic [31:0]  prdata;
  } aogc_regs_t;

endpackage

// [rtl/aogc_core.sv]
// offset and gain correction stage with calibration and diagnostics
`timescale 1ns/1ps
`default_nettype none
`include "aogc_defs.svh"

// Function
// - offset coefficient is signed 16-bit, span one
// - subtract signed offset from filtered value
// - zero offset removes nothing
// - multiply by gain coefficient over 16384
// - gain 5555 hex scales by about 1.3333
// - check overflow, then bipolar or unipolar coding
// - current channel scales offset by K first
// - normal mode K from amplifier gain table
// - low power forces gain 128, K 32
// - low power plus K 8; half-supply doubles
// - reset gain is factory value 5555 hex
// - zero-scale calibration stores new offset
// - full-scale calibration stores new gain
// - current control bits 14,13 drive sources
// - current test code 10 selects reference divide
// - temperature control bits 14,13 drive sources
// - temperature test code 10 selects reference
// - open input reads clamped full scale
// - coefficient writes only while idle; calibration overwrites
// - calibration halts conversion, then returns idle
module aogc_core
  import aogc_pkg::*;
#(
  parameter logic [15:0] FACTORY_GAIN = `AOGC_RST_GAIN
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire aogc_apb_req_t apb_req,
  output aogc_apb_rsp_t      apb_rsp,
  input  wire logic [23:0]   filt_data,
  input  wire logic          filt_valid,
  output aogc_analog_t       ana,
  output logic [15:0]        result_data,
  output logic               result_valid
);

  aogc_regs_t q;
  aogc_regs_t d;

  logic               hit;
  logic               wr;
  logic               rd_setup;
  logic               rd_result;
  logic [3:0]         pga_eff;
  logic [2:0]         kshift;
  logic signed [32:0] koff;
  logic signed [32:0] corr;
  logic signed [49:0] prod;
  logic signed [49:0] scaled;
  logic [15:0]        fmt;
  logic [49:0]        trial;
  logic [15:0]        qbit;
  logic [2:0]         new_mode;
  logic [31:0]        rmux;

  // address decode
  always_comb begin
    case (apb_req.paddr)
      `AOGC_OFS_OFFSET, `AOGC_OFS_GAIN, `AOGC_OFS_MODE,
      `AOGC_OFS_CUR_CTL, `AOGC_OFS_TMP_CTL, `AOGC_OFS_RESULT,
      `AOGC_OFS_STATUS: hit = 1'b1;
      default:          hit = 1'b0;
    endcase
  end

  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & hit;
  assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign rd_result = apb_req.psel & apb_req.penable & ~apb_req.pwrite
                   & (apb_req.paddr == `AOGC_OFS_RESULT);

  // low power modes pin the amplifier at 128
  assign pga_eff = (q.pmode != `AOGC_PWR_NORMAL) ? `AOGC_PGA_128
                 : q.cur_ctl[`AOGC_PGA_HI:`AOGC_PGA_LO];

  // K as a left shift of the offset term
  always_comb begin
    kshift = 3'd0;
    case (q.pmode)
      `AOGC_PWR_LOW:      kshift = q.ref_half ? 3'd6 : 3'd5;
      `AOGC_PWR_LOW_PLUS: kshift = q.ref_half ? 3'd4 : 3'd3;
      default: begin
        case (pga_eff)
          4'h1, 4'h7: kshift = 3'd1;
          4'h8:       kshift = 3'd2;
          4'h9:       kshift = 3'd3;
          default:    kshift = 3'd0;
        endcase
      end
    endcase
  end

  // offset is Q1.15 against the Q1.23 filter word
  assign koff = ($signed({{9{q.off[15]}}, q.off, 8'h00}))
              <<< kshift;
  assign corr = $signed({{9{filt_data[23]}}, filt_data}) - koff;
  assign prod = corr * $signed({1'b0, q.gain});
  assign scaled = (prod >>> (`AOGC_GAIN_ONE_SHIFT + 8))
                + $signed(50'(prod[`AOGC_GAIN_ONE_SHIFT + 7]));

  // clamp to 16 bits, then code the result
  always_comb begin
    if (scaled > 50'sd32767) begin
      fmt = 16'h7FFF;
    end else if (scaled < -50'sd32768) begin
      fmt = 16'h8000;
    end else begin
      fmt = scaled[15:0];
    end
    if (q.unipolar) begin
      fmt = fmt ^ 16'h8000;
    end
  end

  // one quotient bit per cycle: keep bit if bit*d fits 2^38
  assign qbit = q.quo | (16'h0001 << q.bit_i);
  assign trial = 50'(qbit) * 50'(q.div_d);

  assign new_mode = apb_req.pwdata[`AOGC_MODE_HI:`AOGC_MODE_LO];

  // read mux
  always_comb begin
    rmux = 32'h0000_0000;
    case (apb_req.paddr)
      `AOGC_OFS_OFFSET:  rmux = {16'h0000, q.off};
      `AOGC_OFS_GAIN:    rmux = {16'h0000, q.gain};
      `AOGC_OFS_MODE:    rmux = {25'h000_0000, q.unipolar, q.ref_half,
                                 q.pmode, q.mode};
      `AOGC_OFS_CUR_CTL: rmux = {16'h0000, q.cur_ctl};
      `AOGC_OFS_TMP_CTL: rmux = {16'h0000, q.tmp_ctl};
      `AOGC_OFS_RESULT:  rmux = {16'h0000, q.result};
      `AOGC_OFS_STATUS:  rmux = {30'h0000_0000, q.st != AOGC_ST_IDLE,
                                 q.rdy};
      default:           rmux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    if (rd_setup) begin
      d.prdata = rmux;
    end
    if (rd_result) begin
      d.rdy = 1'b0;
    end

    // software writes
    if (wr) begin
      case (apb_req.paddr)
        `AOGC_OFS_OFFSET: begin
          if (q.st == AOGC_ST_IDLE) begin
            d.off = apb_req.pwdata[15:0];
          end
        end
        `AOGC_OFS_GAIN: begin
          if (q.st == AOGC_ST_IDLE) begin
            d.gain = apb_req.pwdata[15:0];
          end
        end
        `AOGC_OFS_MODE: begin
          d.mode = new_mode;
          d.pmode = apb_req.pwdata[`AOGC_PWR_HI:`AOGC_PWR_LO];
          d.ref_half = apb_req.pwdata[`AOGC_REF_HALF_BIT];
          d.unipolar = apb_req.pwdata[`AOGC_UNIPOLAR_BIT];
          case (new_mode)
            `AOGC_MODE_CONT, `AOGC_MODE_SINGLE: d.st = AOGC_ST_CONV;
            `AOGC_MODE_SYS_ZERO: d.st = AOGC_ST_CALZ;
            `AOGC_MODE_SYS_FULL: begin
              d.st = AOGC_ST_CALF;
              d.acc = 33'h0_0000_0000;
              d.nsamp = 1'b0;
            end
            default: begin
              d.st = AOGC_ST_IDLE;
              d.mode = `AOGC_MODE_IDLE;
            end
          endcase
        end
        `AOGC_OFS_CUR_CTL: d.cur_ctl = apb_req.pwdata[15:0];
        `AOGC_OFS_TMP_CTL: d.tmp_ctl = apb_req.pwdata[15:0];
        default: ;
      endcase
    end else begin
      case (q.st)
        AOGC_ST_IDLE: ;
        AOGC_ST_CONV: begin
          if (filt_valid) begin
            d.result = fmt;
            d.rvalid = 1'b1;
            d.rdy = 1'b1;
            if (q.mode == `AOGC_MODE_SINGLE) begin
              d.mode = `AOGC_MODE_IDLE;
              d.st = AOGC_ST_IDLE;
            end
          end
        end
        AOGC_ST_CALZ: begin
          if (filt_valid) begin
            // coefficient that cancels this input after K scaling
            d.off = 16'($signed(filt_data)
                        >>> (4'd8 + 4'(kshift)));
            d.mode = `AOGC_MODE_IDLE;
            d.st = AOGC_ST_IDLE;
          end
        end
        AOGC_ST_CALF: begin
          if (filt_valid) begin
            if (!q.nsamp) begin
              d.acc = corr;
              d.nsamp = 1'b1;
            end else begin
              d.div_d = q.acc + corr;
              d.quo = 16'h0000;
              d.bit_i = 4'hF;
              d.st = AOGC_ST_DIV;
            end
          end
        end
        AOGC_ST_DIV: begin
          if ($signed(q.div_d) <= 33'sd0) begin
            d.gain = 16'hFFFF;
            d.mode = `AOGC_MODE_IDLE;
            d.st = AOGC_ST_IDLE;
          end else begin
            if (trial <= (50'h1 << 38)) begin
              d.quo = qbit;
            end
            if (q.bit_i == 4'h0) begin
              d.gain = (trial <= (50'h1 << 38)) ? qbit : q.quo;
              d.mode = `AOGC_MODE_IDLE;
              d.st = AOGC_ST_IDLE;
            end else begin
              d.bit_i = q.bit_i - 4'h1;
            end
          end
        end
        default: d.st = AOGC_ST_IDLE;
      endcase
    end

    // a new result beats a read clear in the same cycle
    if (d.rvalid) begin
      d.rdy = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= AOGC_ST_IDLE;
      q.off <= `AOGC_RST_OFFSET;
      q.gain <= FACTORY_GAIN;
    end else begin
      q <= d;
    end
  end

  assign apb_rsp.prdata = q.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;

  assign ana.cur_src = {q.cur_ctl[`AOGC_SRC_P_BIT],
                        q.cur_ctl[`AOGC_SRC_N_BIT]};
  assign ana.cur_test = q.cur_ctl[`AOGC_TEST_HI:`AOGC_TEST_LO];
  assign ana.test_div_gain =
    (q.cur_ctl[`AOGC_TEST_HI:`AOGC_TEST_LO] == `AOGC_TEST_REF_DIV)
    & (pga_eff > `AOGC_PGA_128);
  assign ana.pga = pga_eff;
  assign ana.tmp_src = {q.tmp_ctl[`AOGC_SRC_P_BIT],
                        q.tmp_ctl[`AOGC_SRC_N_BIT]};
  assign ana.tmp_test = q.tmp_ctl[`AOGC_TEST_HI:`AOGC_TEST_LO];
  assign ana.conv_run = (q.st != AOGC_ST_IDLE) & (q.st != AOGC_ST_DIV);

  assign result_data = q.result;
  assign result_valid = q.rvalid;

endmodule // aogc_core
`default_nettype wire

// [test/aogc_core_asserts.sv]
// concurrent checks on the ports of the correction block
`timescale 1ns/1ps
`default_nettype none
module aogc_core_asserts
  import aogc_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire aogc_apb_req_t apb_req,
  input wire aogc_apb_rsp_t apb_rsp,
  input wire logic [23:0]   filt_data,
  input wire logic          filt_valid,
  input wire aogc_analog_t  ana,
  input wire logic [15:0]   result_data,
  input wire logic          result_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr(logic [11:0] a);
    apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == a;
  endsequence
  sequence s_mode;
    s_wr(12'h008) ##0 apb_req.pwdata[2:0] != 3'h0;
  endsequence
  sequence s_cal;
    s_mode ##0 (apb_req.pwdata[2:0] inside {3'h5, 3'h6});
  endsequence

  a_cur_src:
    assert property (s_wr(12'h00C) |=>
      ana.cur_src == $past(apb_req.pwdata[14:13])) else $error("cur src");
  a_tmp_src:
    assert property (s_wr(12'h010) |=>
      ana.tmp_src == $past(apb_req.pwdata[14:13])) else $error("tmp src");
  a_cur_test:
    assert property (s_wr(12'h00C) |=>
      ana.cur_test == $past(apb_req.pwdata[7:6])) else $error("cur test");
  a_tmp_test:
    assert property (s_wr(12'h010) |=>
      ana.tmp_test == $past(apb_req.pwdata[7:6])) else $error("tmp test");
  a_div_gain:
    assert property (ana.test_div_gain ==
      (ana.cur_test == 2'b10 && ana.pga > 4'h7)) else $error("div gain");
  a_low_pga:
    assert property (s_wr(12'h008) ##0 apb_req.pwdata[4:3] != 2'h0
      |-> ##[1:2] ana.pga == 4'h7) else $error("pga not forced");
  a_res_cause:
    assert property (result_valid |-> $past(filt_valid))
      else $error("result without sample");
  a_cal_halt:
    assert property (s_cal |=> !result_valid [*2])
      else $error("result after cal start");
  a_idle_stop:
    assert property (s_wr(12'h008) ##0 apb_req.pwdata[2:0] == 3'h0
      |-> ##[1:2] !ana.conv_run) else $error("run in idle");
endmodule // aogc_core_asserts

bind aogc_core aogc_core_asserts aogc_core_asserts_i (
  .clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .filt_data(filt_data), .filt_valid(filt_valid), .ana(ana),
  .result_data(result_data), .result_valid(result_valid));
`default_nettype wire

// [test/test_aogc_core.sv]
// self-checking bench for the offset and gain correction block
`timescale 1ns/1ps
`default_nettype none
`include "aogc_defs.svh"
module test_aogc_core
  import aogc_pkg::*;
;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  aogc_apb_req_t rq = '0;
  aogc_apb_rsp_t rs;
  logic [23:0]   fd = '0;
  logic          fv = 1'b0;
  aogc_analog_t  ana;
  logic [15:0]   rd;
  logic          rv;
  logic [31:0]   rdat, r;
  logic [15:0]   off_m, gain_m, expq[$];
  logic          uni_m, err_r, watch = 1'b1;
  int            k_m, errors = 0, checks = 0, seed = 32'hca63;

  always #20 clk = ~clk;

  aogc_core aogc_core_i (.clk(clk), .rst_n(rst_n), .apb_req(rq),
    .apb_rsp(rs), .filt_data(fd), .filt_valid(fv), .ana(ana),
    .result_data(rd), .result_valid(rv));

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    rq.penable <= 1'b1;
    @(posedge clk);
    while (rs.pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rdat = rs.prdata;
    err_r = rs.pslverr;
    rq <= '0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    cmp(rdat, e);
  endtask

  // current-channel offset scale factor
  function automatic int kf(input logic [1:0] pm, input logic hf,
                            input logic [3:0] g);
    if (pm != 2'h0) return (pm == 2'h1 ? 32 : 8) << hf;
    return g == 4'h1 || g == 4'h7 ? 2
         : g == 4'h8 ? 4 : g == 4'h9 ? 8 : 1;
  endfunction

  function automatic logic [15:0] model(input logic [23:0] f);
    logic signed [63:0] p;
    p = $signed(f) - $signed(off_m) * 256 * k_m;
    p = (p * $signed({1'b0, gain_m}) + 64'sd2097152) >>> 22;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0] ^ {uni_m, 15'h0};
  endfunction

  task automatic smp(input logic [23:0] f);
    @(posedge clk);
    fd <= f;
    fv <= 1'b1;
    if (watch) expq.push_back(model(f));
    @(posedge clk);
    fv <= 1'b0;
    fd <= ~f;
  endtask

  task automatic cfg(input logic [1:0] pm, input logic hf, u,
                     input logic [3:0] g, input logic [15:0] o, gn,
                     input logic [2:0] md);
    apb(1'b1, `AOGC_OFS_MODE, '0);
    apb(1'b1, `AOGC_OFS_OFFSET, {16'h0, o});
    apb(1'b1, `AOGC_OFS_GAIN, {16'h0, gn});
    apb(1'b1, `AOGC_OFS_CUR_CTL, {28'h0, g});
    off_m = o;
    gain_m = gn;
    k_m = kf(pm, hf, g);
    uni_m = u;
    apb(1'b1, `AOGC_OFS_MODE, {25'h0, u, hf, pm, md});
  endtask

  task automatic idle_wait;
    int n;
    n = 0;
    do begin
      apb(1'b0, `AOGC_OFS_MODE, '0);
      n++;
    end while (rdat[2:0] !== 3'h0 && n < 30);
    cmp(rdat[2:0], 3'h0);
  endtask

  always @(negedge clk)
    if (rv === 1'b1 && watch)
      cmp(rd, expq.size() ? expq.pop_front() : 'x);

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`AOGC_OFS_OFFSET, 32'h0000_0000);
    rchk(`AOGC_OFS_GAIN, 32'h0000_5555);
    rchk(12'h0FC, 32'h0000_0000);
    cmp(err_r, 1'b1);
    rchk(`AOGC_OFS_MODE, 32'h0000_0000);
    cmp(err_r, 1'b0);
    for (int pm = 0; pm < 3; pm++)
      for (int g = 0; g < 10; g++) begin
        r = $random(seed);
        cfg(pm[1:0], r[20], r[21], g[3:0], {{9{r[6]}}, r[6:0]},
            r[31:16], 3'h1);
        repeat (2) @(negedge clk);
        cmp(ana.pga, pm ? 4'h7 : g[3:0]);
        repeat (3) smp($random(seed));
      end
    apb(1'b1, `AOGC_OFS_OFFSET, 32'h0000_1234);
    rchk(`AOGC_OFS_OFFSET, {16'h0, off_m});
    cfg(2'h0, 1'b0, 1'b0, 4'h0, 16'h0000, 16'hFFFF, 3'h1);
    smp(24'h7F_FFFF);
    smp(24'h80_0000);
    rchk(`AOGC_OFS_RESULT, 32'h0000_8000);
    cfg(2'h0, 1'b0, 1'b1, 4'h3, 16'h0000, 16'h4000, 3'h2);
    smp(24'h12_3456);
    idle_wait;
    watch = 1'b0;
    cfg(2'h0, 1'b0, 1'b0, 4'h8, 16'h0100, 16'h4000, 3'h5);
    smp(24'hF0_0000);
    idle_wait;
    rchk(`AOGC_OFS_OFFSET, 32'h0000_FC00);
    cfg(2'h0, 1'b0, 1'b0, 4'h0, 16'h0000, 16'h4000, 3'h6);
    smp(24'h30_0000);
    smp(24'h30_0000);
    idle_wait;
    rchk(`AOGC_OFS_GAIN, 32'h0000_AAAA);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      if (i < 4) {r[23:22], r[7:6]} = 4'b1010;
      r[3:0] = 4'(i + 2);
      apb(1'b1, `AOGC_OFS_CUR_CTL, {16'h0, r[15:0]});
      apb(1'b1, `AOGC_OFS_TMP_CTL, {16'h0, r[31:16]});
      repeat (2) @(negedge clk);
      cmp(ana.cur_src, r[14:13]);
      cmp(ana.cur_test, r[7:6]);
      cmp(ana.test_div_gain, r[7:6] == 2'b10 && r[3:0] > 4'h7);
      cmp(ana.tmp_src, r[30:29]);
      cmp(ana.tmp_test, r[23:22]);
    end
    cmp(expq.size(), 0);
    complete_run;
  end

  initial begin
    #400000;
    errors++;
    complete_run;
  end
endmodule // test_aogc_core
`default_nettype wire
